// file: verilog/dct_defs.svh
/*
 * Constants for the DMA cycle timing select block: field positions of the
 * extended mode byte, reset values, and the bus clock period counts per timing.
 * Assumes it is included by bare name after the package dct_pkg.
 */
`ifndef DCT_DEFS_SVH
`define DCT_DEFS_SVH

// ------------------------------------------------------------------
// Extended mode byte layout
// ------------------------------------------------------------------
`define DCT_SEL_MSB          1
`define DCT_SEL_LSB          0
`define DCT_STORE_MSB        7
`define DCT_STORE_LSB        2
`define DCT_STORE_W          6
// Timing field sits at bits 5:4 of the byte, i.e. bits 3:2 of the stored part.
`define DCT_TM_MSB           3
`define DCT_TM_LSB           2
`define DCT_NUM_CH           8

// ------------------------------------------------------------------
// Reset values of the stored part, bits 7:2 of the byte
// ------------------------------------------------------------------
`define DCT_RST_DMA1         6'h00
`define DCT_RST_DMA2         6'h01

// ------------------------------------------------------------------
// Clock and bus clock timing
// ------------------------------------------------------------------
`define DCT_CLK_PERIOD_NS    8
`define DCT_ISA_CLK_NS       120
`define DCT_ISA_CLK_DIV      ((`DCT_ISA_CLK_NS + `DCT_CLK_PERIOD_NS - 1) / `DCT_CLK_PERIOD_NS)

// ------------------------------------------------------------------
// Repeated cycle phases in bus clock periods: setup, command, recovery
// ------------------------------------------------------------------
`define DCT_COMPAT_SETUP     4'h2
`define DCT_COMPAT_CMD       4'h5
`define DCT_A_SETUP          4'h2
`define DCT_A_CMD            4'h3
`define DCT_B_SETUP          4'h1
`define DCT_B_CMD            4'h3
`define DCT_F_SETUP          4'h1
`define DCT_F_CMD            4'h1
`define DCT_RECOVERY         4'h1
// A single compatible cycle carries one extra lead period ahead of the setup.
`define DCT_SINGLE_LEAD      4'h1

`endif

// file: verilog/dct_pkg.sv
/*
 * Types for the DMA cycle timing select block.
 * Assumes nothing of its surroundings.
 */
package dct_pkg;

    typedef enum logic [1:0] {
        DCT_TM_COMPAT = 2'b00,
        DCT_TM_A      = 2'b01,
        DCT_TM_B      = 2'b10,
        DCT_TM_F      = 2'b11
    } dct_timing_t;

    typedef enum logic {
        DCT_ST_IDLE = 1'b0,
        DCT_ST_RUN  = 1'b1
    } dct_state_t;

endpackage : dct_pkg

// file: verilog/dct_cycle_timer.sv
/*
 * Counts one DMA cycle in bus clock periods and opens the command window.
 * Assumes a one-cycle bus clock enable and phase lengths held stable by the caller
 * from the load pulse to the done pulse.
 */
`timescale 1ns/1ps
`include "dct_defs.svh"

module dct_cycle_timer
    import dct_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       sys_tick,
    input  wire logic       load,
    input  wire logic [3:0] lead_len,
    input  wire logic [3:0] setup_len,
    input  wire logic [3:0] cmd_len,
    output logic            busy,
    output logic            done,
    output logic            cmd_active,
    output logic [3:0]      period
);

    // ------------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------------
    dct_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic       done_q, done_d;
    logic       cmd_q, cmd_d;
    logic [3:0] cmd_start;
    logic [3:0] cmd_stop;
    logic [3:0] total;

    assign cmd_start = 4'(lead_len + setup_len);
    assign cmd_stop  = 4'(cmd_start + cmd_len);
    assign total     = 4'(cmd_stop + `DCT_RECOVERY);

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        done_d  = 1'b0;
        cmd_d   = cmd_q;
        unique case (state_q)
            DCT_ST_IDLE: begin
                if (load) begin
                    state_d = DCT_ST_RUN;
                    // The first tick only lines the cycle up with a bus clock edge and
                    // wraps the count to zero, so every phase lasts whole periods.
                    cnt_d   = 4'hF;
                    cmd_d   = 1'b0;
                end
            end
            DCT_ST_RUN: begin
                if (sys_tick) begin
                    // The command opens after the setup periods and closes before recovery.
                    cnt_d = 4'(cnt_q + 4'h1);
                    cmd_d = (cnt_d >= cmd_start) && (cnt_d < cmd_stop);
                    if (cnt_d == total) begin
                        state_d = DCT_ST_IDLE;
                        done_d  = 1'b1;
                        cmd_d   = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= DCT_ST_IDLE;
            cnt_q   <= 4'h0;
            done_q  <= 1'b0;
            cmd_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            done_q  <= done_d;
            cmd_q   <= cmd_d;
        end
    end

    assign busy       = (state_q == DCT_ST_RUN);
    assign done       = done_q;
    assign cmd_active = cmd_q;
    assign period     = cnt_q;

endmodule : dct_cycle_timer

// file: verilog/dct_timing_select.sv
/*
 * Per-channel DMA cycle timing selection: stores bits 7:2 of the extended mode byte of
 * eight channels and times each DMA cycle in bus clock periods.
 * Assumes a 125 MHz clk, a DMA engine that issues cycle starts and extended
 * mode writes as one-cycle pulses, and ISA slaves that meet the chosen timing.
 */
// Behaviour
// R1: every channel holds a two-bit timing code: compatible, A, B or F.
// R2: bus reset returns every channel's timing code to compatible.
// R3: cycles aimed at ISA expansion memory run with compatible timing.
// R4: compatible cycles take nine bus clocks single, eight when repeated.
// R5: type A repeated cycles take six bus clocks.
// R6: type A keeps compatible setup windows but shortens the command.
// R7: type B repeated cycles take five bus clocks.
// R8: type B shortens write setup and read access; slaves must keep up.
// R9: type B is meant only for fast main memory transfers.
// R10: type F repeated cycles take three bus clocks.
// R11: write bits 1:0 pick the channel and are dropped; bits 7:2 stored.
// R12: cycle counter loads the active channel's code, fallback applied first.
`timescale 1ns/1ps
`include "dct_defs.svh"

module dct_timing_select
    import dct_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    pci_bus_reset_n,
    input  wire logic                    ext_mode_wr,
    input  wire logic                    ext_mode_group,
    input  wire logic [7:0]              ext_mode_data,
    input  wire logic                    cyc_start,
    input  wire logic [2:0]              cyc_channel,
    input  wire logic                    cyc_isa_mem,
    input  wire logic                    cyc_repeat,
    output logic                         cyc_ready,
    output logic                         cyc_busy,
    output logic                         cyc_done,
    output logic [1:0]                   cyc_timing,
    output logic [3:0]                   cyc_length,
    output logic                         cmd_active,
    output logic                         isa_system_clock,
    output logic [2*`DCT_NUM_CH-1:0]     ch_timing
);

    logic rstn;
    assign rstn = pci_bus_reset_n;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [3:0] dct_setup(input dct_timing_t tm);
        logic [3:0] r;
        r = `DCT_COMPAT_SETUP;
        unique case (tm)
            DCT_TM_COMPAT: r = `DCT_COMPAT_SETUP;
            DCT_TM_A:      r = `DCT_A_SETUP;                           // R6
            DCT_TM_B:      r = `DCT_B_SETUP;                           // R8
            DCT_TM_F:      r = `DCT_F_SETUP;
        endcase
        return r;
    endfunction : dct_setup

    function automatic logic [3:0] dct_cmd(input dct_timing_t tm);
        logic [3:0] r;
        r = `DCT_COMPAT_CMD;
        unique case (tm)
            DCT_TM_COMPAT: r = `DCT_COMPAT_CMD;
            DCT_TM_A:      r = `DCT_A_CMD;                             // R6
            DCT_TM_B:      r = `DCT_B_CMD;
            DCT_TM_F:      r = `DCT_F_CMD;
        endcase
        return r;
    endfunction : dct_cmd

    // ------------------------------------------------------------------
    // Bus clock enable divider
    // ------------------------------------------------------------------
    localparam logic [3:0] DIV_LAST = 4'(`DCT_ISA_CLK_DIV - 1);
    logic [3:0] div_q, div_d;
    logic       tick_q, tick_d;
    logic       half_q, half_d;

    always_comb begin
        tick_d = (div_q == DIV_LAST);
        div_d  = tick_d ? 4'h0 : 4'(div_q + 4'h1);
        half_d = (div_q < 4'(`DCT_ISA_CLK_DIV / 2));
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_q  <= 4'h0;
            tick_q <= 1'b0;
            half_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
            half_q <= half_d;
        end
    end

    assign isa_system_clock = half_q;

    // ------------------------------------------------------------------
    // Extended mode storage, bits 7:2 per channel
    // ------------------------------------------------------------------
    logic [2:0] wr_ch;
    assign wr_ch = {ext_mode_group, ext_mode_data[`DCT_SEL_MSB:`DCT_SEL_LSB]};   // R11

    logic [`DCT_STORE_W-1:0] mode_q [`DCT_NUM_CH];

    genvar g;
    generate
        for (g = 0; g < `DCT_NUM_CH; g++) begin : g_ch
            localparam logic [`DCT_STORE_W-1:0] RST_VAL =
                (g < 4) ? `DCT_RST_DMA1 : `DCT_RST_DMA2;
            logic [`DCT_STORE_W-1:0] mode_d;

            always_comb begin
                mode_d = mode_q[g];
                if (ext_mode_wr && (wr_ch == 3'(g))) begin
                    mode_d = ext_mode_data[`DCT_STORE_MSB:`DCT_STORE_LSB];   // R11
                end
            end

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    mode_q[g] <= RST_VAL;                               // R2
                end else begin
                    mode_q[g] <= mode_d;
                end
            end

            assign ch_timing[2*g+1:2*g] = mode_q[g][`DCT_TM_MSB:`DCT_TM_LSB];   // R1
        end
    endgenerate

    // ------------------------------------------------------------------
    // Cycle set-up: the code is latched at start so a later write to the
    // same channel cannot change a cycle that is already running.
    // ------------------------------------------------------------------
    dct_timing_t tm_sel;
    dct_timing_t tm_q, tm_d;
    logic        lead_q, lead_d;
    logic [3:0]  len_q, len_d;
    logic        timer_busy;
    logic        load;
    logic [3:0]  setup_len;
    logic [3:0]  cmd_len;
    logic [3:0]  lead_len;

    always_comb begin
        tm_sel = dct_timing_t'(mode_q[cyc_channel][`DCT_TM_MSB:`DCT_TM_LSB]);   // R12
        // ISA expansion memory cannot take the fast modes; B also needs main memory.
        if (cyc_isa_mem) begin
            tm_sel = DCT_TM_COMPAT;                                     // R3 R9
        end
    end

    assign cyc_ready = !timer_busy;
    assign load      = cyc_start && cyc_ready;

    always_comb begin
        tm_d   = tm_q;
        lead_d = lead_q;
        len_d  = len_q;
        if (load) begin
            tm_d   = tm_sel;                                            // R12
            // Only compatible timing has a single-cycle length of its own.
            lead_d = !cyc_repeat && (tm_sel == DCT_TM_COMPAT);          // R4
            len_d  = 4'(dct_setup(tm_sel) + dct_cmd(tm_sel) + `DCT_RECOVERY
                        + (lead_d ? `DCT_SINGLE_LEAD : 4'h0));          // R4 R5 R7 R10
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tm_q   <= DCT_TM_COMPAT;
            lead_q <= 1'b0;
            len_q  <= 4'h0;
        end else begin
            tm_q   <= tm_d;
            lead_q <= lead_d;
            len_q  <= len_d;
        end
    end

    // The timer starts one clock after load, once the latched code has settled.
    logic load_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            load_q <= 1'b0;
        end else begin
            load_q <= load;
        end
    end

    assign setup_len = dct_setup(tm_q);                                 // R6 R8
    assign cmd_len   = dct_cmd(tm_q);
    assign lead_len  = lead_q ? `DCT_SINGLE_LEAD : 4'h0;

    logic run_busy;

    dct_cycle_timer u_timer (
        .clk        (clk),
        .rstn       (rstn),
        .sys_tick   (tick_q),
        .load       (load_q),
        .lead_len   (lead_len),
        .setup_len  (setup_len),
        .cmd_len    (cmd_len),
        .busy       (run_busy),
        .done       (cyc_done),
        .cmd_active (cmd_active),
        .period     ()
    );

    assign timer_busy = run_busy || load_q;
    assign cyc_busy   = timer_busy;
    assign cyc_timing = tm_q;
    assign cyc_length = len_q;

endmodule : dct_timing_select

// file: tb/dct_isa_slave.sv
/* ISA DMA slave seen from the expansion bus side of the timing block.
   Assumes it sees the command window and the bus reset only. */
`timescale 1ns/1ps
module dct_isa_slave (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       cmd_active,
    output logic [7:0]      cmd_clks
);
    // ------------------------------------------------------------
    // Command window width
    // ------------------------------------------------------------
    logic [7:0] run_q;
    // The slave records the width of any window it is given, however short.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_q    <= 8'h00;
            cmd_clks <= 8'h00;
        end else if (cmd_active) begin
            run_q <= run_q + 8'h01;
        end else if (run_q != 8'h00) begin
            cmd_clks <= run_q;
            run_q    <= 8'h00;
        end
    end
endmodule : dct_isa_slave

// file: tb/dct_timing_select_chk.sv
/* Assertions on the ports of the timing select block.
   Assumes one clock and the active-low bus reset of the top module. */
`timescale 1ns/1ps
`include "dct_defs.svh"
module dct_chk
    import dct_pkg::*;
(
    input wire logic        clk,
    input wire logic        pci_bus_reset_n,
    input wire logic        ext_mode_wr,
    input wire logic        ext_mode_group,
    input wire logic [7:0]  ext_mode_data,
    input wire logic        cyc_start,
    input wire logic [2:0]  cyc_channel,
    input wire logic        cyc_isa_mem,
    input wire logic        cyc_repeat,
    input wire logic        cyc_ready,
    input wire logic        cyc_busy,
    input wire logic        cyc_done,
    input wire logic [1:0]  cyc_timing,
    input wire logic [3:0]  cyc_length,
    input wire logic        cmd_active,
    input wire logic        isa_system_clock,
    input wire logic [15:0] ch_timing
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic [7:0] age_q;
    logic [7:0] age_d;
    logic       rep_q;
    logic [2:0] wch_q;
    logic [1:0] wcode_q;
    logic [3:0] len_e;
    logic       acc;
    logic [1:0] sel_code;
    assign acc      = cyc_start && cyc_ready;
    assign sel_code = ch_timing[{cyc_channel, 1'b0} +: 2];
    always_comb begin
        age_d = age_q;
        if (acc) begin
            age_d = 8'h00;
        end else if (age_q != 8'hFF) begin
            age_d = age_q + 8'h01;
        end
        case (cyc_timing)
            2'b00:   len_e = rep_q ? 4'h8 : 4'h9;
            2'b01:   len_e = 4'h6;
            2'b10:   len_e = 4'h5;
            default: len_e = 4'h3;
        endcase
    end
    always_ff @(posedge clk or negedge pci_bus_reset_n) begin
        if (!pci_bus_reset_n) begin
            age_q   <= 8'h00;
            rep_q   <= 1'b0;
            wch_q   <= 3'h0;
            wcode_q <= 2'h0;
        end else begin
            age_q   <= age_d;
            rep_q   <= acc ? cyc_repeat : rep_q;
            wch_q   <= {ext_mode_group, ext_mode_data[1:0]};
            wcode_q <= ext_mode_data[5:4];
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!pci_bus_reset_n);
    chk_ready_inverse: assert property (cyc_ready == !cyc_busy)
        else $error("ready is not the inverse of busy");
    chk_reset_compat: assert property ($rose(pci_bus_reset_n) |-> ch_timing == 16'h0000)
        else $error("timing codes not compatible after reset");
    chk_write_store: assert property (ext_mode_wr |=> ch_timing[{wch_q, 1'b0} +: 2] == wcode_q)
        else $error("written timing code not stored");
    chk_isa_compat: assert property (acc && cyc_isa_mem |=> cyc_timing == 2'b00)
        else $error("expansion memory cycle not compatible");
    chk_code_pick: assert property (acc && !cyc_isa_mem |=> cyc_timing == $past(sel_code))
        else $error("cycle did not use the stored code");
    chk_length_map: assert property (acc |=> cyc_busy && cyc_length == len_e)
        else $error("cycle length does not match timing");
    chk_done_window: assert property (cyc_done |->
        age_q > cyc_length * `DCT_ISA_CLK_DIV && age_q <= cyc_length * `DCT_ISA_CLK_DIV + 16)
        else $error("done outside the cycle length");
    chk_done_pulse: assert property (cyc_done |-> !cyc_busy ##1 !cyc_done)
        else $error("done not a single pulse");
    chk_cmd_inside: assert property (cmd_active |-> cyc_busy)
        else $error("command window outside a cycle");
    chk_start_refused: assert property (cyc_start && cyc_busy |=>
        $stable(cyc_timing) && $stable(cyc_length))
        else $error("start taken while busy");
endmodule : dct_chk
bind dct_timing_select dct_chk chk_u (
    .clk(clk), .pci_bus_reset_n(pci_bus_reset_n), .ext_mode_wr(ext_mode_wr),
    .ext_mode_group(ext_mode_group), .ext_mode_data(ext_mode_data),
    .cyc_start(cyc_start), .cyc_channel(cyc_channel), .cyc_isa_mem(cyc_isa_mem),
    .cyc_repeat(cyc_repeat), .cyc_ready(cyc_ready), .cyc_busy(cyc_busy),
    .cyc_done(cyc_done), .cyc_timing(cyc_timing), .cyc_length(cyc_length),
    .cmd_active(cmd_active), .isa_system_clock(isa_system_clock), .ch_timing(ch_timing)
);

// file: tb/testbench.sv
/* Self-checking bench for the timing select block and an ISA slave model.
   Assumes the design files and the checker are compiled first. */
`timescale 1ns/1ps
`include "dct_defs.svh"
module testbench;
    logic clk, rstn, wr, grp, start, isa, rep, ready, busy, done, cmd, isa_clk;
    logic [7:0]  data;
    logic [2:0]  ch;
    logic [1:0]  timing;
    logic [3:0]  length;
    logic [15:0] codes;
    logic [7:0]  cmd_clks;
    int err_total = 0;
    int compares  = 0;
    int cycles    = 0;
    dct_timing_select dut_u (.clk(clk), .pci_bus_reset_n(rstn), .ext_mode_wr(wr),
        .ext_mode_group(grp), .ext_mode_data(data), .cyc_start(start), .cyc_channel(ch),
        .cyc_isa_mem(isa), .cyc_repeat(rep), .cyc_ready(ready), .cyc_busy(busy),
        .cyc_done(done), .cyc_timing(timing), .cyc_length(length), .cmd_active(cmd),
        .isa_system_clock(isa_clk), .ch_timing(codes));
    dct_isa_slave slave_u (.clk(clk), .rstn(rstn), .cmd_active(cmd), .cmd_clks(cmd_clks));
    // ------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask : check
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic wr_mode(input logic [2:0] c, input logic [1:0] code);
        @(negedge clk);
        wr   = 1'b1;
        grp  = c[2];
        data = {2'b01, code, 2'b10, c[1:0]};
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_mode
    task automatic wait_idle(output int n);
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_idle
    task automatic run_cyc(input logic [2:0] c, input logic m, input logic r,
                           input logic [1:0] code, input logic [3:0] len, input logic [3:0] cp);
        int n;
        @(negedge clk);
        start = 1'b1;
        ch    = c;
        isa   = m;
        rep   = r;
        @(negedge clk);
        start = 1'b0;
        check("timing", timing, code);
        check("length", length, len);
        wait_idle(n);
        check("done_window", (n > len * `DCT_ISA_CLK_DIV) &&
              (n <= len * `DCT_ISA_CLK_DIV + 16), 1);
        check("cmd_clks", cmd_clks, cp * `DCT_ISA_CLK_DIV);
    endtask : run_cyc
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_program();
        check("reset_codes", codes, 16'h0000);
        check("ready", ready, 1);
        for (int i = 0; i < 8; i++) wr_mode(i[2:0], i[1:0]);
        @(negedge clk);
        check("codes", codes, 16'hE4E4);
        $display("test program done");
    endtask : t_program
    task automatic t_lengths();
        logic [3:0] len[4] = '{4'h8, 4'h6, 4'h5, 4'h3};
        logic [3:0] cp[4]  = '{4'h5, 4'h3, 4'h3, 4'h1};
        for (int i = 0; i < 4; i++) run_cyc(i[2:0], 0, 1, i[1:0], len[i], cp[i]);
        run_cyc(3'd4, 0, 0, 2'b00, 4'h9, 4'h5);
        run_cyc(3'd5, 0, 0, 2'b01, 4'h6, 4'h3);
        run_cyc(3'd3, 1, 1, 2'b00, 4'h8, 4'h5);
        run_cyc(3'd6, 1, 1, 2'b00, 4'h8, 4'h5);
        $display("test lengths done");
    endtask : t_lengths
    task automatic t_refuse();
        int n;
        @(negedge clk);
        start = 1'b1;
        ch    = 3'd7;
        rep   = 1'b1;
        isa   = 1'b0;
        @(negedge clk);
        ch   = 3'd0;
        wr   = 1'b1;
        grp  = 1'b1;
        data = 8'h03;
        @(negedge clk);
        start = 1'b0;
        wr    = 1'b0;
        wait_idle(n);
        check("kept_timing", timing, 2'b11);
        check("kept_length", length, 4'h3);
        run_cyc(3'd7, 0, 1, 2'b00, 4'h8, 4'h5);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_bus_clock();
        int highs;
        highs = 0;
        // Two whole periods hold the high phase twice, whatever the phase at entry.
        repeat (2 * `DCT_ISA_CLK_DIV) begin
            @(negedge clk);
            if (isa_clk === 1'b1) highs++;
        end
        check("bus_clock_high", 16'(highs), 16'(2 * (`DCT_ISA_CLK_DIV / 2)));
        $display("test bus_clock done");
    endtask : t_bus_clock
    task automatic t_reset_mid();
        @(negedge clk);
        start = 1'b1;
        ch    = 3'd1;
        @(negedge clk);
        start = 1'b0;
        repeat (20) @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        check("busy_reset", busy, 0);
        check("codes_reset", codes, 16'h0000);
        rstn = 1'b1;
        run_cyc(3'd1, 0, 1, 2'b00, 4'h8, 4'h5);
        $display("test reset_mid done");
    endtask : t_reset_mid
    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        {rstn, wr, grp, start, isa, rep} = 6'h00;
        data = 8'h00;
        ch   = 3'h0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        t_program();
        t_bus_clock();
        t_lengths();
        t_refuse();
        t_reset_mid();
        summarize();
    end
endmodule : testbench
